// ===== core/uef_endpoint_core.sv
// Endpoint FIFO transaction core: firmware FIFO access and USB bulk/interrupt/setup handling.
// Assumes an SIE that decodes tokens and bytes, and an Avalon-MM master on the register side.
`timescale 1ns/100ps
`default_nettype none
module uef_endpoint_core #(
  parameter int NUM_EP = 3,
  parameter int DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tok_valid,
  input wire uef_pkg::uef_tok_t tok_kind,
  input wire logic [1:0] tok_ep,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic tx_end,
  input wire logic usb_ack,
  output logic hs_ack,
  output logic hs_nak,
  output logic usb_irq
);
  import uef_pkg::*;
  localparam int PW = $clog2(DEPTH) + 1;
  localparam int MW = PW + 2;

  if (NUM_EP < 1 || NUM_EP > 4 || DEPTH < 8 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("uef_endpoint_core: NUM_EP must be 1..4, DEPTH a power of two 8..128");
  end

  function automatic logic [MW-1:0] mem_idx(input logic [1:0] ep, input logic bk,
                                            input logic [PW-1:0] p);
    mem_idx = {ep, bk, p[PW-2:0]};
  endfunction
  function automatic logic is_ctrl(input logic [7:0] c);
    is_ctrl = c[CFG_TYPE_LSB +: 2] == EP_CONTROL;
  endfunction
  function automatic logic is_pp(input logic [7:0] c);
    is_pp = c[CFG_PP_BIT] && !is_ctrl(c);
  endfunction

  logic [7:0] mem_q [4*2*DEPTH];
  logic [7:0] cfg_q [4];
  logic [PW-1:0] fw_ptr_q [4][2];
  logic [7:0] cnt_q [4][2];
  logic [3:0] rx0_q, rx1_q, setup_q, cmpl_q, dir_q, rdy0_q, rdy1_q, fw_bk_q, usb_bk_q;
  logic [1:0] sel_q;
  logic [3:0] ie_q;
  uef_state_t state_q;
  logic [1:0] cur_ep_q;
  logic cur_bk_q, accept_q, ignore_q, is_setup_q;
  logic [PW-1:0] usb_ptr_q;
  logic [7:0] rx_cnt_q, tx_len_q;

  // Firmware side decode
  logic acc, rd_dat, wr_dat, wr_st, set_rdy, cancel, clr_rx0;
  logic cur_fb, cur_rdy;
  logic [PW-1:0] cur_ptr;
  logic [7:0] cur_cnt, d, st_rd, rd_mux;
  assign acc = (avs_read || avs_write) && !avs_waitrequest;
  assign d = avs_writedata[7:0];
  assign rd_dat = acc && avs_read && avs_address == A_DATA;
  assign wr_dat = acc && avs_write && avs_address == A_DATA;
  assign wr_st = acc && avs_write && avs_address == A_STATUS;
  assign cur_fb = fw_bk_q[sel_q];
  assign cur_ptr = fw_ptr_q[sel_q][cur_fb];
  assign cur_cnt = cnt_q[sel_q][cur_fb];
  assign cur_rdy = cur_fb ? rdy1_q[sel_q] : rdy0_q[sel_q];
  assign set_rdy = wr_st && d[SB_RDY_BIT] && !cur_rdy;
  assign cancel = wr_st && !d[SB_RDY_BIT] && !is_pp(cfg_q[sel_q]) && rdy0_q[sel_q];
  assign clr_rx0 = wr_st && !d[SB_RX0_BIT] && rx0_q[sel_q];

  // USB side decode
  logic [7:0] tok_cfg;
  logic tok_ok, tok_bk, tok_in_ok, tok_rdy, tok_free, rx_store, in_done;
  assign tok_cfg = cfg_q[tok_ep];
  assign tok_ok = 3'(tok_ep) < 3'(NUM_EP) && tok_cfg[CFG_EN_BIT]
                  && tok_cfg[CFG_TYPE_LSB +: 2] != EP_ISO;
  assign tok_bk = is_pp(tok_cfg) ? usb_bk_q[tok_ep] : 1'b0;
  assign tok_in_ok = is_ctrl(tok_cfg) ? dir_q[tok_ep] : tok_cfg[CFG_DIR_BIT];
  assign tok_rdy = tok_bk ? rdy1_q[tok_ep] : rdy0_q[tok_ep];
  assign tok_free = !(tok_bk ? rx1_q[tok_ep] : rx0_q[tok_ep])
                    && !(is_ctrl(tok_cfg) && setup_q[tok_ep]);
  assign rx_store = state_q == S_RX && rx_end && accept_q && rx_crc_ok;
  assign in_done = state_q == S_ACK && usb_ack;

  always_comb begin
    st_rd = 8'h00;
    st_rd[SB_CMPL_BIT] = cmpl_q[sel_q];
    st_rd[SB_RX0_BIT] = rx0_q[sel_q];
    st_rd[SB_SETUP_BIT] = setup_q[sel_q];
    st_rd[SB_RDY_BIT] = cur_rdy;
    st_rd[SB_RX1_BIT] = rx1_q[sel_q];
    st_rd[SB_DIR_BIT] = dir_q[sel_q];
  end

  always_comb begin
    case (avs_address)
      A_SELECT: rd_mux = {6'h00, sel_q};
      A_CONFIG: rd_mux = cfg_q[sel_q];
      A_STATUS: rd_mux = st_rd;
      A_DATA: rd_mux = mem_q[mem_idx(sel_q, cur_fb, cur_ptr)];
      A_COUNT: rd_mux = cur_cnt;
      A_IRQ_EN: rd_mux = {4'h0, ie_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Avalon slave: answer one cycle after a request appears
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= {24'h00_0000, rd_mux};
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Global registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= SEL_RST;
      ie_q <= IE_RST;
      usb_irq <= 1'b0;
    end else begin
      if (acc && avs_write && avs_address == A_SELECT) sel_q <= d[1:0];
      if (acc && avs_write && avs_address == A_IRQ_EN) ie_q <= d[3:0];
      usb_irq <= |(ie_q & (rx0_q | rx1_q | setup_q | cmpl_q));
    end
  end

  // FIFO storage
  always_ff @(posedge clk_sys) begin
    if (wr_dat && !cur_ptr[PW-1]) mem_q[mem_idx(sel_q, cur_fb, cur_ptr)] <= d;
    if (state_q == S_RX && rx_valid && accept_q && !usb_ptr_q[PW-1])
      mem_q[mem_idx(cur_ep_q, cur_bk_q, usb_ptr_q)] <= rx_data;
  end

  // Endpoint state: firmware updates first, USB updates last so a USB set or clear wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int e = 0; e < 4; e++) begin
        cfg_q[e] <= CFG_RST;
        fw_ptr_q[e][0] <= '0;
        fw_ptr_q[e][1] <= '0;
        cnt_q[e][0] <= 8'h00;
        cnt_q[e][1] <= 8'h00;
      end
      {rx0_q, rx1_q, setup_q, cmpl_q} <= 16'h0000;
      {dir_q, rdy0_q, rdy1_q, fw_bk_q, usb_bk_q} <= 20'h00000;
    end else begin
      for (int e = 0; e < 4; e++) begin
        if (2'(e) == sel_q) begin
          if (acc && avs_write && avs_address == A_CONFIG) cfg_q[e] <= d;
          if ((rd_dat || wr_dat) && !cur_ptr[PW-1])
            fw_ptr_q[e][fw_bk_q[e]] <= cur_ptr + 1'b1;
          if (wr_st) begin
            dir_q[e] <= d[SB_DIR_BIT];
            if (!d[SB_CMPL_BIT]) cmpl_q[e] <= 1'b0;
            if (!d[SB_SETUP_BIT]) setup_q[e] <= 1'b0;
            if (clr_rx0) begin
              rx0_q[e] <= 1'b0;
              fw_ptr_q[e][0] <= '0;
              if (is_pp(cfg_q[e])) fw_bk_q[e] <= 1'b1;
            end
            if (!d[SB_RX1_BIT] && rx1_q[e]) begin
              rx1_q[e] <= 1'b0;
              fw_ptr_q[e][1] <= '0;
              fw_bk_q[e] <= 1'b0;
            end
            if (set_rdy) begin
              if (fw_bk_q[e]) rdy1_q[e] <= 1'b1;
              else rdy0_q[e] <= 1'b1;
              cnt_q[e][fw_bk_q[e]] <= 8'(cur_ptr);
              if (is_pp(cfg_q[e])) fw_bk_q[e] <= !fw_bk_q[e];
            end
            if (cancel) begin
              rdy0_q[e] <= 1'b0;
              fw_ptr_q[e][0] <= '0;
              cnt_q[e][0] <= 8'h00;
            end
          end
        end
        if (rx_store && cur_ep_q == 2'(e)) begin
          cnt_q[e][cur_bk_q] <= rx_cnt_q;
          fw_ptr_q[e][cur_bk_q] <= '0;
          if (is_setup_q) begin
            setup_q[e] <= 1'b1;
            {rx0_q[e], rx1_q[e], cmpl_q[e], rdy0_q[e], rdy1_q[e]} <= 5'h00;
          end else begin
            if (cur_bk_q) rx1_q[e] <= 1'b1;
            else rx0_q[e] <= 1'b1;
            if (is_pp(cfg_q[e])) usb_bk_q[e] <= !cur_bk_q;
          end
        end
        if (in_done && cur_ep_q == 2'(e)) begin
          cmpl_q[e] <= 1'b1;
          if (cur_bk_q) rdy1_q[e] <= 1'b0;
          else rdy0_q[e] <= 1'b0;
          fw_ptr_q[e][cur_bk_q] <= '0;
          if (is_pp(cfg_q[e])) usb_bk_q[e] <= !cur_bk_q;
        end
      end
    end
  end

  // USB transaction sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      {cur_ep_q, cur_bk_q, accept_q, ignore_q, is_setup_q} <= 6'h00;
      usb_ptr_q <= '0;
      rx_cnt_q <= 8'h00;
      tx_len_q <= 8'h00;
      {tx_valid, tx_end, hs_ack, hs_nak} <= 4'h0;
      tx_data <= 8'h00;
    end else begin
      hs_ack <= 1'b0;
      hs_nak <= 1'b0;
      tx_end <= 1'b0;
      case (state_q)
        S_IDLE, S_ACK: begin
          // Unacknowledged data stays ready; a retry token in the ACK wait is served at once
          if (state_q == S_ACK && usb_ack) begin
            state_q <= S_IDLE;
          end else if (tok_valid && tok_ok) begin
            state_q <= S_IDLE;
            cur_ep_q <= tok_ep;
            cur_bk_q <= tok_bk;
            usb_ptr_q <= '0;
            rx_cnt_q <= 8'h00;
            is_setup_q <= tok_kind == TOK_SETUP;
            if (tok_kind == TOK_IN) begin
              if (tok_in_ok && tok_rdy) begin
                state_q <= S_TX;
                tx_len_q <= cnt_q[tok_ep][tok_bk];
              end else if (tok_in_ok) begin
                hs_nak <= 1'b1;
              end
            end else begin
              state_q <= S_RX;
              if (tok_kind == TOK_SETUP) begin
                ignore_q <= !is_ctrl(tok_cfg);
                accept_q <= is_ctrl(tok_cfg);
              end else begin
                ignore_q <= !is_ctrl(tok_cfg) && tok_cfg[CFG_DIR_BIT];
                accept_q <= tok_free && !(!is_ctrl(tok_cfg) && tok_cfg[CFG_DIR_BIT]);
              end
            end
          end
        end
        S_RX: begin
          if (rx_valid) begin
            if (!usb_ptr_q[PW-1]) usb_ptr_q <= usb_ptr_q + 1'b1;
            if (rx_cnt_q != CNT_MAX) rx_cnt_q <= rx_cnt_q + 8'h01;
          end
          if (rx_end) begin
            state_q <= S_IDLE;
            if (!ignore_q && rx_crc_ok) begin
              hs_ack <= accept_q;
              hs_nak <= !accept_q;
            end
          end
        end
        S_TX: begin
          if (tx_valid) begin
            if (tx_ready) begin
              tx_valid <= 1'b0;
              usb_ptr_q <= usb_ptr_q + 1'b1;
            end
          end else if (8'(usb_ptr_q) == tx_len_q) begin
            tx_end <= 1'b1;
            state_q <= S_ACK;
          end else begin
            tx_valid <= 1'b1;
            tx_data <= mem_q[mem_idx(cur_ep_q, cur_bk_q, usb_ptr_q)];
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_read_step: assert property (rd_dat && !cur_ptr[PW-1] && !rx_store && !in_done
    |=> cur_ptr == $past(cur_ptr) + 1'b1) else $error("data read did not step address");
  a_count_hold: assert property ((rd_dat || wr_dat) && !rx_store
    |=> $stable(cur_cnt)) else $error("byte count moved on data access");
  a_out_flag0: assert property (rx_store && !is_setup_q && !cur_bk_q
    |=> rx0_q[$past(cur_ep_q)]) else $error("bank0 flag not set");
  a_out_flag1: assert property (rx_store && !is_setup_q && cur_bk_q
    |=> rx1_q[$past(cur_ep_q)]) else $error("bank1 flag not set");
  a_byte_load: assert property (rx_store
    |=> cnt_q[$past(cur_ep_q)][$past(cur_bk_q)] == $past(rx_cnt_q))
    else $error("byte count not loaded");
  a_out_nak: assert property (state_q == S_RX && rx_end && rx_crc_ok && !ignore_q
    && !accept_q |=> hs_nak && !hs_ack) else $error("busy OUT not refused");
  a_bank_swap: assert property (clr_rx0 && is_pp(cfg_q[sel_q])
    |=> fw_bk_q[$past(sel_q)]) else $error("bank swap missing");
  a_in_send: assert property (state_q == S_IDLE && tok_valid && tok_kind == TOK_IN
    && tok_ok && tok_in_ok && tok_rdy |=> state_q == S_TX ##[1:520] tx_end)
    else $error("ready IN not sent");
  a_in_nak: assert property (state_q == S_IDLE && tok_valid && tok_kind == TOK_IN
    && tok_ok && tok_in_ok && !tok_rdy |=> hs_nak && state_q == S_IDLE)
    else $error("unready IN not refused");
  a_cancel: assert property (cancel && !rx_store
    |=> !rdy0_q[$past(sel_q)] && fw_ptr_q[$past(sel_q)][0] == '0)
    else $error("cancel did not empty packet");
  a_in_cmpl: assert property (in_done |=> cmpl_q[$past(cur_ep_q)]
    && state_q == S_IDLE) else $error("complete flag not set");
  a_setup_rx: assert property (rx_store && is_setup_q
    |=> setup_q[$past(cur_ep_q)] && !rx0_q[$past(cur_ep_q)])
    else $error("setup receipt wrong");
  a_flag_hold: assert property (cmpl_q[sel_q] && !wr_st && !rx_store
    |=> cmpl_q[$past(sel_q)]) else $error("complete flag lost");

  c_setup: cover property (rx_store && is_setup_q);
  c_zlp_out: cover property (rx_store && rx_cnt_q == 8'h00);
  c_in_done: cover property (in_done);
  c_pp_swap: cover property (clr_rx0 && is_pp(cfg_q[sel_q]));
endmodule // uef_endpoint_core
`default_nettype wire

// ===== core/uef_pkg.sv
// Constants and types of the endpoint FIFO transaction core.
// Assumes it is compiled before the core and the bench.
package uef_pkg;
  localparam logic [4:0] A_SELECT = 5'h00;
  localparam logic [4:0] A_CONFIG = 5'h04;
  localparam logic [4:0] A_STATUS = 5'h08;
  localparam logic [4:0] A_DATA = 5'h0c;
  localparam logic [4:0] A_COUNT = 5'h10;
  localparam logic [4:0] A_IRQ_EN = 5'h14;
  localparam int SB_CMPL_BIT = 0;
  localparam int SB_RX0_BIT = 1;
  localparam int SB_SETUP_BIT = 2;
  localparam int SB_RDY_BIT = 4;
  localparam int SB_RX1_BIT = 6;
  localparam int SB_DIR_BIT = 7;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_DIR_BIT = 2;
  localparam int CFG_PP_BIT = 3;
  localparam int CFG_EN_BIT = 7;
  localparam logic [1:0] EP_CONTROL = 2'h0;
  localparam logic [1:0] EP_ISO = 2'h1;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [3:0] IE_RST = 4'h0;
  localparam logic [7:0] CNT_MAX = 8'hff;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_RX = 4'h2,
    S_TX = 4'h4,
    S_ACK = 4'h8
  } uef_state_t;
  typedef enum logic [1:0] {
    TOK_OUT = 2'h0,
    TOK_IN = 2'h1,
    TOK_SETUP = 2'h2
  } uef_tok_t;
endpackage

// ===== bench/uef_host_model.sv
// USB host and SIE stand-in: issues tokens, sends OUT/SETUP data, takes IN data.
// Assumes the core samples all of these signals on the rising edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none
module uef_host_model (
  input wire logic clk_sys,
  output logic tok_valid,
  output var uef_pkg::uef_tok_t tok_kind,
  output logic [1:0] tok_ep,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_crc_ok,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic tx_end,
  output logic usb_ack,
  input wire logic hs_ack,
  input wire logic hs_nak
);
  import uef_pkg::*;
  int hs;
  logic ended;
  logic [7:0] q[$];
  initial begin
    tok_valid = 1'b0;
    tok_kind = TOK_OUT;
    tok_ep = 2'h0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    rx_crc_ok = 1'b0;
    tx_ready = 1'b0;
    usb_ack = 1'b0;
    hs = 0;
    ended = 1'b0;
  end
  task automatic tok(input uef_tok_t k, input logic [1:0] e);
    tok_valid <= 1'b1;
    tok_kind <= k;
    tok_ep <= e;
    @(posedge clk_sys);
    tok_valid <= 1'b0;
    tok_ep <= ~e;
  endtask
  // Data packet then handshake capture; released data line shows the inverse
  task automatic send(input uef_tok_t k, input logic [1:0] e, input int n, input logic [7:0] b);
    int i;
    hs = 0;
    tok(k, e);
    for (i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= b + i[7:0];
      @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    rx_crc_ok <= 1'b1;
    @(posedge clk_sys);
    rx_end <= 1'b0;
    rx_crc_ok <= 1'b0;
    for (i = 0; i < 6 && hs == 0; i++) begin
      @(posedge clk_sys);
      if (hs_ack === 1'b1) hs = 1;
      else if (hs_nak === 1'b1) hs = 2;
    end
    @(posedge clk_sys);
  endtask
  // IN token; slow takes bytes every other cycle; no ack leaves a retry pending
  task automatic fetch(input logic [1:0] e, input logic slow, input logic ack);
    int i;
    hs = 0;
    ended = 1'b0;
    q.delete();
    tok(TOK_IN, e);
    for (i = 0; i < 200 && !ended && hs == 0; i++) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      @(posedge clk_sys);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) q.push_back(tx_data);
      if (tx_end === 1'b1) ended = 1'b1;
      if (hs_nak === 1'b1) hs = 2;
    end
    tx_ready <= 1'b0;
    @(posedge clk_sys);
    usb_ack <= ack & ended;
    @(posedge clk_sys);
    usb_ack <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule // uef_host_model
`default_nettype wire

// ===== bench/tb.sv
// Testbench: firmware traffic over Avalon-MM plus a host model on the USB side.
// Assumes the core answers each bus request after one wait cycle.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import uef_pkg::*;
  localparam int DP = 8;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  logic tok_valid, rx_valid, rx_end, rx_crc_ok, tx_valid, tx_ready, tx_end;
  logic usb_ack, hs_ack, hs_nak, usb_irq;
  uef_tok_t tok_kind;
  logic [1:0] tok_ep;
  logic [7:0] rx_data, tx_data;
  int err_count = 0;
  int n_checks = 0;
  uef_endpoint_core #(.NUM_EP(4), .DEPTH(DP)) i_uef_endpoint_core (.clk_sys, .rst_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .tok_valid, .tok_kind, .tok_ep, .rx_valid, .rx_data, .rx_end, .rx_crc_ok, .tx_valid,
    .tx_data, .tx_ready, .tx_end, .usb_ack, .hs_ack, .hs_nak, .usb_irq);
  uef_host_model i_uef_host_model (.clk_sys, .tok_valid, .tok_kind, .tok_ep, .rx_valid,
    .rx_data, .rx_end, .rx_crc_ok, .tx_valid, .tx_data, .tx_ready, .tx_end, .usb_ack,
    .hs_ack, .hs_nak);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      err_count++;
      results();
    end
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd_q, {24'h0, e});
  endtask
  task automatic rdn(input int n, input logic [7:0] b);
    for (int k = 0; k < n; k++) rd(A_DATA, b + k[7:0]);
  endtask
  task automatic wrn(input int n, input logic [7:0] b);
    for (int k = 0; k < n; k++) wr(A_DATA, b + k[7:0]);
  endtask
  task automatic snd(input uef_tok_t t, input logic [1:0] e, input int n, input logic [7:0] b,
      input int h);
    i_uef_host_model.send(t, e, n, b);
    chk(i_uef_host_model.hs, h);
  endtask
  task automatic fin(input logic [1:0] e, input logic s, input logic a, input int n,
      input logic [7:0] b);
    i_uef_host_model.fetch(e, s, a);
    chk(i_uef_host_model.ended, n >= 0);
    if (n < 0) chk(i_uef_host_model.hs, 2);
    else chk(i_uef_host_model.q.size(), n);
    for (int k = 0; k < n; k++) chk(i_uef_host_model.q[k], b + k[7:0]);
  endtask
  task automatic t_reset();
    rd(A_SELECT, 8'h00);
    rd(A_CONFIG, 8'h00);
    rd(A_STATUS, 8'h00);
    rd(A_IRQ_EN, 8'h00);
    rd(A_COUNT, 8'h00);
    rd(5'h1c, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_out();
    wr(A_SELECT, 8'h02);
    wr(A_CONFIG, 8'h82);
    wr(A_IRQ_EN, 8'h04);
    snd(TOK_OUT, 2'h2, 3, 8'h10, 1);
    rd(A_STATUS, 8'h02);
    chk(usb_irq, 1);
    rd(A_COUNT, 8'h03);
    rdn(3, 8'h10);
    rd(A_COUNT, 8'h03);
    snd(TOK_OUT, 2'h2, 2, 8'h20, 2);
    rd(A_STATUS, 8'h02);
    wr(A_STATUS, 8'h00);
    rd(A_STATUS, 8'h00);
    chk(usb_irq, 0);
    snd(TOK_OUT, 2'h2, 0, 8'h00, 1);
    rd(A_COUNT, 8'h00);
    wr(A_STATUS, 8'h00);
    snd(TOK_OUT, 2'h2, 10, 8'h30, 1);
    rd(A_COUNT, 8'h0a);
    rdn(DP, 8'h30);
    wr(A_STATUS, 8'h00);
    $display("t_out done");
  endtask
  task automatic t_pp_out();
    wr(A_SELECT, 8'h03);
    wr(A_CONFIG, 8'h8b);
    snd(TOK_OUT, 2'h3, 2, 8'h40, 1);
    snd(TOK_OUT, 2'h3, 3, 8'h50, 1);
    rd(A_STATUS, 8'h42);
    snd(TOK_OUT, 2'h3, 1, 8'h60, 2);
    rd(A_COUNT, 8'h02);
    rdn(2, 8'h40);
    wr(A_STATUS, 8'h40);
    rd(A_COUNT, 8'h03);
    rdn(3, 8'h50);
    snd(TOK_OUT, 2'h3, 1, 8'h60, 1);
    rd(A_STATUS, 8'h42);
    wr(A_STATUS, 8'h02);
    rd(A_COUNT, 8'h01);
    rdn(1, 8'h60);
    wr(A_STATUS, 8'h00);
    $display("t_pp_out done");
  endtask
  task automatic t_in();
    wr(A_SELECT, 8'h01);
    wr(A_CONFIG, 8'h86);
    fin(2'h1, 1'b0, 1'b0, -1, 8'h00);
    wrn(3, 8'ha0);
    rd(A_COUNT, 8'h00);
    wr(A_STATUS, 8'h10);
    fin(2'h1, 1'b1, 1'b0, 3, 8'ha0);
    fin(2'h1, 1'b0, 1'b1, 3, 8'ha0);
    rd(A_STATUS, 8'h01);
    wr(A_STATUS, 8'h00);
    wr(A_STATUS, 8'h10);
    fin(2'h1, 1'b0, 1'b1, 0, 8'h00);
    wr(A_STATUS, 8'h00);
    wrn(2, 8'hb0);
    wr(A_STATUS, 8'h10);
    wr(A_STATUS, 8'h00);
    fin(2'h1, 1'b0, 1'b0, -1, 8'h00);
    wrn(1, 8'hc0);
    wr(A_STATUS, 8'h10);
    fin(2'h1, 1'b0, 1'b1, 1, 8'hc0);
    wr(A_STATUS, 8'h00);
    $display("t_in done");
  endtask
  task automatic t_pp_in();
    wr(A_SELECT, 8'h02);
    wr(A_CONFIG, 8'h8e);
    wrn(2, 8'hd0);
    wr(A_STATUS, 8'h10);
    wrn(2, 8'he0);
    wr(A_STATUS, 8'h10);
    fin(2'h2, 1'b1, 1'b1, 2, 8'hd0);
    wr(A_STATUS, 8'h00);
    fin(2'h2, 1'b0, 1'b1, 2, 8'he0);
    wr(A_STATUS, 8'h00);
    fin(2'h2, 1'b0, 1'b0, -1, 8'h00);
    $display("t_pp_in done");
  endtask
  task automatic t_setup();
    wr(A_SELECT, 8'h00);
    wr(A_CONFIG, 8'h80);
    wr(A_IRQ_EN, 8'h01);
    snd(TOK_OUT, 2'h0, 1, 8'h70, 1);
    snd(TOK_SETUP, 2'h0, 8, 8'h80, 1);
    rd(A_STATUS, 8'h04);
    chk(usb_irq, 1);
    rd(A_COUNT, 8'h08);
    rdn(8, 8'h80);
    wr(A_STATUS, 8'h00);
    rd(A_STATUS, 8'h00);
    $display("t_setup done");
  endtask
  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_out();
    t_pp_out();
    t_in();
    t_pp_in();
    t_setup();
    results();
  end
  initial begin
    #2000000;
    err_count++;
    results();
  end
endmodule // tb
`default_nettype wire
